//--- ctrl_signals_top.sv
// two binary control signal channels behind an apb register file
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "ctrl_signals_params.svh"
module ctrl_signals_top #(
  parameter int NUM_SRC = `CS_NUM_SRC,
  parameter int SEC_CYCLES = `CS_SEC_CYCLES
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // binary sources and cycle interval tick
  input wire logic [NUM_SRC-1:0] SIGNALS,
  input wire logic CYCLE_TICK,
  // control outputs
  output ctrl_signals_pkg::ctrl_vec_t CTRL_OUT
);
  import ctrl_signals_pkg::*;

  chan_cfg_t cfg [`CS_NUM_CH];
  logic [31:0] status_word [`CS_NUM_CH];
  logic sec_en;
  logic apb_setup_done;
  logic apb_write;
  logic ch_sel;
  logic [4:0] reg_off;
  logic addr_ok;
  logic [31:0] rd_word;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);

  // over-range writes saturate instead of wrapping
  function automatic logic [`CS_TIME_W-1:0] clamp_time(input logic [31:0] v);
    clamp_time = (v > {18'h00000, `CS_TIME_MAX}) ? `CS_TIME_MAX : v[`CS_TIME_W-1:0];
  endfunction

  function automatic logic addr_valid(input logic [7:0] a);
    addr_valid = (a[7:6] == 2'h0) && (a[1:0] == 2'h0) && (a[4:0] <= `CS_OFF_STAT);
  endfunction

  // zero limit ends at once; otherwise on the tick that completes it
  function automatic logic timer_done(input logic [`CS_TIME_W-1:0] cnt,
                                      input logic [`CS_TIME_W-1:0] lim,
                                      input logic tick);
    timer_done = (lim == '0) || (tick && (({1'b0, cnt} + 15'h0001) >= {1'b0, lim}));
  endfunction

  sec_tick_gen #(.PERIOD(SEC_CYCLES)) u_sec (.clk(CLOCK), .rst(RESET), .tick(sec_en));

  assign apb_setup_done = PSEL & PENABLE & ~PREADY;
  assign apb_write = PSEL & PENABLE & PREADY & PWRITE;
  assign ch_sel = PADDR[`CS_CH_BIT];
  assign reg_off = PADDR[4:0];
  assign addr_ok = addr_valid(PADDR);

  // one wait state keeps pready, prdata and pslverr on flip-flops
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= apb_setup_done;
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case (reg_off)
      `CS_OFF_CFG: rd_word = {27'h0000000, cfg[ch_sel].invert, cfg[ch_sel].func};
      `CS_OFF_SEL: rd_word = {11'h000, cfg[ch_sel].src3, 3'h0, cfg[ch_sel].src2,
                              3'h0, cfg[ch_sel].src1};
      `CS_OFF_ON: rd_word = {18'h00000, cfg[ch_sel].on_time};
      `CS_OFF_OFF: rd_word = {18'h00000, cfg[ch_sel].off_time};
      `CS_OFF_PULSE: rd_word = {18'h00000, cfg[ch_sel].pulse_time};
      `CS_OFF_STAT: rd_word = status_word[ch_sel];
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (apb_setup_done) begin
      PSLVERR <= ~addr_ok;
      PRDATA <= (addr_ok && !PWRITE) ? rd_word : 32'h0000_0000;
    end else begin
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      for (int i = 0; i < `CS_NUM_CH; i++) begin
        cfg[i] <= CFG_RESET;
      end
    end else if (apb_write && addr_ok) begin
      case (reg_off)
        `CS_OFF_CFG: begin
          cfg[ch_sel].func <= func_t'(PWDATA[3:0]);
          cfg[ch_sel].invert <= PWDATA[`CS_CFG_INV_BIT];
        end
        `CS_OFF_SEL: begin
          cfg[ch_sel].src1 <= PWDATA[`CS_SEL1_LSB +: `CS_SEL_W];
          cfg[ch_sel].src2 <= PWDATA[`CS_SEL2_LSB +: `CS_SEL_W];
          cfg[ch_sel].src3 <= PWDATA[`CS_SEL3_LSB +: `CS_SEL_W];
        end
        `CS_OFF_ON: cfg[ch_sel].on_time <= clamp_time(PWDATA);
        `CS_OFF_OFF: cfg[ch_sel].off_time <= clamp_time(PWDATA);
        `CS_OFF_PULSE: cfg[ch_sel].pulse_time <= clamp_time(PWDATA);
        default: begin
        end
      endcase
    end
  end

  for (genvar ch = 0; ch < `CS_NUM_CH; ch++) begin : g_ch
    logic v1, v2, v3, s1, s2, s3;
    logic prim, prim_q, rise, fall, trig;
    logic link_or, link_and, link_xor;
    logic dly_out, edge_arm, edge_act, result;
    logic [`CS_TIME_W-1:0] cnt;
    logic [`CS_TIME_W-1:0] dly_lim;
    state_t state;

    sig_select #(.NUM_SRC(NUM_SRC), .SEL_W(`CS_SEL_W)) u_s1 (.sel(cfg[ch].src1),
      .signals(SIGNALS), .valid(v1), .value(s1));
    sig_select #(.NUM_SRC(NUM_SRC), .SEL_W(`CS_SEL_W)) u_s2 (.sel(cfg[ch].src2),
      .signals(SIGNALS), .valid(v2), .value(s2));
    sig_select #(.NUM_SRC(NUM_SRC), .SEL_W(`CS_SEL_W)) u_s3 (.sel(cfg[ch].src3),
      .signals(SIGNALS), .valid(v3), .value(s3));

    assign prim = v1 & s1;
    assign rise = prim & ~prim_q;
    assign fall = ~prim & prim_q;
    assign trig = ((cfg[ch].func == F_RISE) & rise) | ((cfg[ch].func == F_FALL) & fall);
    // unselected second and third operands drop out: neutral for and, zero for or and xor
    assign link_or = s1 | (v2 & s2) | (v3 & s3);
    assign link_and = s1 & (~v2 | s2) & (~v3 | s3);
    assign link_xor = s1 ^ (v2 & s2) ^ (v3 & s3);
    assign dly_lim = prim ? cfg[ch].on_time : cfg[ch].off_time;
    assign status_word[ch] = {2'h0, cnt, 10'h000, edge_act, dly_out, state, prim, CTRL_OUT[ch]};

    always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
        prim_q <= 1'b0;
      end else begin
        prim_q <= prim;
      end
    end

    // one counter serves pulse, delay and single pulse; a mode switch does not clear it itself, but leaving delay mode starts it from zero
    always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
        state <= S_LOW;
        cnt <= '0;
      end else begin
        unique case (cfg[ch].func)
          F_PULSE: begin
            if (!prim) begin
              state <= S_LOW;
              cnt <= '0;
            end else begin
              unique case (state)
                S_LOW: begin
                  state <= S_HIGH;
                  cnt <= '0;
                end
                S_HIGH: begin
                  if (timer_done(cnt, cfg[ch].on_time, sec_en)) begin
                    // zero off time keeps the output high instead of a one-cycle dip
                    state <= (cfg[ch].off_time == '0) ? S_HIGH : S_GAP;
                    cnt <= '0;
                  end else if (sec_en) begin
                    cnt <= cnt + `CS_TIME_W'(1);
                  end
                end
                S_GAP: begin
                  if (timer_done(cnt, cfg[ch].off_time, sec_en)) begin
                    state <= S_HIGH;
                    cnt <= '0;
                  end else if (sec_en) begin
                    cnt <= cnt + `CS_TIME_W'(1);
                  end
                end
                default: begin
                  state <= S_LOW;
                  cnt <= '0;
                end
              endcase
            end
          end
          F_DELAY: begin
            state <= S_LOW;
            if (prim == dly_out || timer_done(cnt, dly_lim, sec_en)) begin
              cnt <= '0;
            end else if (sec_en) begin
              cnt <= cnt + `CS_TIME_W'(1);
            end
          end
          F_SINGLE: begin
            if (rise) begin
              state <= (cfg[ch].pulse_time == '0) ? S_LOW : S_HIGH;
              cnt <= '0;
            end else if (state == S_HIGH) begin
              if (timer_done(cnt, cfg[ch].pulse_time, sec_en)) begin
                state <= S_LOW;
                cnt <= '0;
              end else if (sec_en) begin
                cnt <= cnt + `CS_TIME_W'(1);
              end
            end else begin
              state <= S_LOW;
              cnt <= '0;
            end
          end
          default: begin
            state <= S_LOW;
            cnt <= '0;
          end
        endcase
      end
    end

    // an unfinished delay is dropped when the input returns
    always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
        dly_out <= 1'b0;
      end else if (cfg[ch].func != F_DELAY) begin
        dly_out <= 1'b0;
      end else if (prim != dly_out && timer_done(cnt, dly_lim, sec_en)) begin
        dly_out <= prim;
      end
    end

    // output aligned to the next full cycle interval; a new edge wins over the clear
    always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
        edge_arm <= 1'b0;
        edge_act <= 1'b0;
      end else if (cfg[ch].func != F_RISE && cfg[ch].func != F_FALL) begin
        edge_arm <= 1'b0;
        edge_act <= 1'b0;
      end else if (CYCLE_TICK) begin
        edge_act <= edge_arm;
        edge_arm <= trig;
      end else begin
        edge_arm <= edge_arm | trig;
      end
    end

    always_comb begin
      result = 1'b0;
      if (v1) begin
        unique case (cfg[ch].func)
          F_NONE: result = prim;
          F_PULSE: result = (state == S_HIGH) && (cfg[ch].on_time != '0);
          F_DELAY: result = dly_out;
          F_SINGLE: result = (state == S_HIGH);
          F_RISE, F_FALL: result = edge_act;
          F_OR: result = link_or;
          F_AND: result = link_and;
          F_XOR: result = link_xor;
          default: result = 1'b0;
        endcase
      end
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
        CTRL_OUT[ch] <= 1'b0;
      end else begin
        CTRL_OUT[ch] <= result ^ cfg[ch].invert;
      end
    end

    property p_none;
      $past(cfg[ch].func == F_NONE) |-> CTRL_OUT[ch] == $past(cfg[ch].invert ^ prim);
    endproperty
    a_none: assert property (p_none) else $error("no-function output mismatch");
    property p_pulse_idle;
      (cfg[ch].func == F_PULSE && !prim && !cfg[ch].invert) [*2] |=> !CTRL_OUT[ch];
    endproperty
    a_pulse_idle: assert property (p_pulse_idle) else $error("pulse active on low input");
    property p_pulse_high;
      (cfg[ch].func == F_PULSE && state == S_HIGH && cfg[ch].on_time != '0 && v1
       && !cfg[ch].invert) |=> CTRL_OUT[ch];
    endproperty
    a_pulse_high: assert property (p_pulse_high) else $error("pulse high phase lost");
    property p_delay_rise;
      (cfg[ch].func == F_DELAY && $rose(dly_out)) |->
        $past(prim && timer_done(cnt, cfg[ch].on_time, sec_en));
    endproperty
    a_delay_rise: assert property (p_delay_rise) else $error("delayed rise too early");
    property p_delay_fall;
      (cfg[ch].func == F_DELAY && $fell(dly_out)) |->
        $past(!prim && timer_done(cnt, cfg[ch].off_time, sec_en));
    endproperty
    a_delay_fall: assert property (p_delay_fall) else $error("delayed fall too early");
    property p_single_end;
      (cfg[ch].func == F_SINGLE && state == S_HIGH && !rise
       && timer_done(cnt, cfg[ch].pulse_time, sec_en)) |=> state == S_LOW;
    endproperty
    a_single_end: assert property (p_single_end) else $error("single pulse did not end");
    property p_single_restart;
      (cfg[ch].func == F_SINGLE && rise && cfg[ch].pulse_time != '0)
        |=> (state == S_HIGH && cnt == '0);
    endproperty
    a_single_restart: assert property (p_single_restart) else $error("no restart");
    property p_edge_tick;
      $rose(edge_act) |-> $past(CYCLE_TICK && edge_arm);
    endproperty
    a_edge_tick: assert property (p_edge_tick) else $error("edge output off the tick");
    property p_fall_arm;
      (cfg[ch].func == F_FALL && fall) |=> edge_arm;
    endproperty
    a_fall_arm: assert property (p_fall_arm) else $error("falling edge missed");
    property p_xor;
      $past(cfg[ch].func == F_XOR) |-> CTRL_OUT[ch] == $past(cfg[ch].invert ^ (v1 & link_xor));
    endproperty
    a_xor: assert property (p_xor) else $error("xor link mismatch");
    property p_unsel;
      !v1 |=> CTRL_OUT[ch] == $past(cfg[ch].invert);
    endproperty
    a_unsel: assert property (p_unsel) else $error("unselected primary not inactive");
    c_single: cover property (cfg[ch].func == F_SINGLE && $fell(state == S_HIGH));
    c_delay: cover property (cfg[ch].func == F_DELAY && $rose(dly_out));
    c_edge: cover property (cfg[ch].func == F_FALL && $rose(edge_act));
  end

  property p_sec;
    sec_en |=> !sec_en;
  endproperty
  a_sec: assert property (p_sec) else $error("second tick longer than one cycle");
endmodule // ctrl_signals_top

//--- ctrl_signals_params.svh
// constants of the control signal block: offsets, fields, resets, timing
`ifndef CTRL_SIGNALS_PARAMS_SVH
`define CTRL_SIGNALS_PARAMS_SVH
`define CS_NUM_CH 2
`define CS_NUM_SRC 16
`define CS_SEL_W 5
`define CS_TIME_W 14
`define CS_TIME_MAX 14'h270f
`define CS_TIME_RST 14'h0000
`define CS_SEL_RST 5'h00
`define CS_INV_RST 1'b0
`define CS_CH_BIT 5
`define CS_OFF_CFG 5'h00
`define CS_OFF_SEL 5'h04
`define CS_OFF_ON 5'h08
`define CS_OFF_OFF 5'h0c
`define CS_OFF_PULSE 5'h10
`define CS_OFF_STAT 5'h14
`define CS_CFG_INV_BIT 4
`define CS_SEL1_LSB 0
`define CS_SEL2_LSB 8
`define CS_SEL3_LSB 16
`define CS_CLK_HZ 10000000
`define CS_ONE_SEC_S 1
`define CS_SEC_CYCLES (`CS_ONE_SEC_S * `CS_CLK_HZ)
`endif

//--- ctrl_signals_pkg.sv
// types of the control signal block
`include "ctrl_signals_params.svh"
package ctrl_signals_pkg;
  typedef enum logic [3:0] {
    F_NONE = 4'h0,
    F_PULSE = 4'h1,
    F_DELAY = 4'h2,
    F_SINGLE = 4'h3,
    F_RISE = 4'h4,
    F_FALL = 4'h5,
    F_OR = 4'h6,
    F_AND = 4'h7,
    F_XOR = 4'h8
  } func_t;
  typedef enum logic [1:0] {
    S_LOW = 2'b00,
    S_HIGH = 2'b01,
    S_GAP = 2'b10
  } state_t;
  typedef struct packed {
    func_t func;
    logic invert;
    logic [`CS_SEL_W-1:0] src1;
    logic [`CS_SEL_W-1:0] src2;
    logic [`CS_SEL_W-1:0] src3;
    logic [`CS_TIME_W-1:0] on_time;
    logic [`CS_TIME_W-1:0] off_time;
    logic [`CS_TIME_W-1:0] pulse_time;
  } chan_cfg_t;
  typedef logic [`CS_NUM_CH-1:0] ctrl_vec_t;
  localparam chan_cfg_t CFG_RESET = '{func: F_NONE, invert: `CS_INV_RST,
    src1: `CS_SEL_RST, src2: `CS_SEL_RST, src3: `CS_SEL_RST,
    on_time: `CS_TIME_RST, off_time: `CS_TIME_RST, pulse_time: `CS_TIME_RST};
endpackage

//--- sec_tick_gen.sv
// divider making a one-cycle enable pulse once per period
`timescale 1ns/1ps
module sec_tick_gen #(
  parameter int PERIOD = 10000000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // one-cycle enable
  output logic tick
);
  localparam int CW = $clog2(PERIOD + 1);
  logic [CW-1:0] cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (cnt == CW'(PERIOD - 1)) begin
      cnt <= '0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + CW'(1);
      tick <= 1'b0;
    end
  end
endmodule // sec_tick_gen

//--- sig_select.sv
// picks one binary source by number, zero meaning no selection
`timescale 1ns/1ps
module sig_select #(
  parameter int NUM_SRC = 16,
  parameter int SEL_W = 5
) (
  // selection
  input wire logic [SEL_W-1:0] sel,
  input wire logic [NUM_SRC-1:0] signals,
  // result
  output logic valid,
  output logic value
);
  always_comb begin
    valid = (sel != '0) && (32'(sel) <= NUM_SRC);
    value = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (32'(sel) == i + 1) begin
        value = signals[i];
      end
    end
  end
endmodule // sig_select

//--- src_model.sv
// partner model: binary sources and cycle interval tick feeding the control block
`timescale 1ns/1ps
module src_model #(
  parameter int TICK_PERIOD = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // levels asked for by the bench
  input wire logic [15:0] want,
  // towards the block
  output logic [15:0] signals,
  output logic cycle_tick
);
  int cnt;
  // sources change only after an edge, like a synchronous selector
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      signals <= '0;
    end else begin
      signals <= want;
    end
  end
  // free-running interval, one-cycle pulse per period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      cycle_tick <= 1'b0;
    end else begin
      cnt <= (cnt == TICK_PERIOD - 1) ? 0 : cnt + 1;
      cycle_tick <= (cnt == TICK_PERIOD - 1);
    end
  end
endmodule // src_model

//--- tb.sv
// self-checking bench for the two control signal channels
`timescale 1ns/1ps
module tb;
  import ctrl_signals_pkg::*;
  // short second keeps the run brief
  localparam int SEC = 4;
  localparam int TP = 6;
  logic CLOCK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, CYCLE_TICK;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [15:0] SIGNALS, want;
  ctrl_vec_t CTRL_OUT;
  int err_total, checks_done;

  ctrl_signals_top #(.NUM_SRC(16), .SEC_CYCLES(SEC)) u_ctrl_signals_top (
    .CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SIGNALS(SIGNALS), .CYCLE_TICK(CYCLE_TICK), .CTRL_OUT(CTRL_OUT));
  src_model #(.TICK_PERIOD(TP)) u_src_model (.clk(CLOCK), .rst(RESET), .want(want),
    .signals(SIGNALS), .cycle_tick(CYCLE_TICK));

  always #50 CLOCK = ~CLOCK;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one idle edge first, so a release never meets a new setup in one step
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int i;
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr_en;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge CLOCK);
      if (PREADY === 1'b1) break;
    end
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (i == 20) begin
      err_total++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(what, q, exp);
    check({what, "_err"}, {31'h0, e}, 32'h0);
  endtask

  task automatic set(input logic [7:0] b, input func_t f, input logic inv,
                     input logic [4:0] s1, s2, s3);
    wr(b, {27'h0, inv, f});
    wr(b + 8'h04, {11'h0, s3, 3'h0, s2, 3'h0, s1});
  endtask

  task automatic drive(input logic [15:0] v);
    @(posedge CLOCK);
    want <= v;
  endtask

  // cycles until channel 0 shows the level; a hang ends the run
  task automatic wait_lvl(input logic v, input int lim, output int n);
    for (n = 1; n <= lim; n++) begin
      @(posedge CLOCK);
      if (CTRL_OUT[0] === v) return;
    end
    err_total++;
    $display("[FAIL] wait_lvl expected %h seen %h", v, CTRL_OUT[0]);
    finish_test();
  endtask

  task automatic t_reset_regs();
    logic [31:0] q;
    logic e;
    check("out_reset", {30'h0, CTRL_OUT}, 32'h0);
    rd("cfg_reset", 8'h00, 32'h0);
    rd("on_reset", 8'h28, 32'h0);
    rd("pulse_reset", 8'h10, 32'h0);
    rd("stat_reset", 8'h14, 32'h0);
    wr(8'h28, 32'h2710);
    rd("on_sat", 8'h28, 32'h270f);
    wr(8'h10, 32'h270f);
    rd("pulse_max", 8'h10, 32'h270f);
    apb(1'b0, 8'h18, 32'h0, q, e);
    check("unmapped_err", {31'h0, e}, 32'h1);
  endtask

  task automatic t_none_inv();
    set(8'h00, F_NONE, 1'b0, 5'h01, 5'h00, 5'h00);
    set(8'h20, F_NONE, 1'b0, 5'h04, 5'h00, 5'h00);
    drive(16'h0001);
    repeat (3) @(posedge CLOCK);
    check("none_ch0", {30'h0, CTRL_OUT}, 32'h1);
    drive(16'h0008);
    repeat (3) @(posedge CLOCK);
    check("none_ch1", {30'h0, CTRL_OUT}, 32'h2);
    set(8'h00, F_NONE, 1'b1, 5'h01, 5'h00, 5'h00);
    repeat (3) @(posedge CLOCK);
    check("invert", {31'h0, CTRL_OUT[0]}, 32'h1);
    set(8'h20, F_NONE, 1'b0, 5'h00, 5'h00, 5'h00);
    repeat (3) @(posedge CLOCK);
    check("no_primary", {31'h0, CTRL_OUT[1]}, 32'h0);
  endtask

  task automatic t_links();
    func_t fl[3];
    logic [2:0] v;
    logic ex;
    fl = '{F_OR, F_AND, F_XOR};
    for (int i = 0; i < 3; i++) begin
      set(8'h00, fl[i], 1'b0, 5'h01, 5'h02, 5'h03);
      for (int k = 0; k < 8; k++) begin
        v = 3'(k);
        drive({13'h0, v});
        repeat (3) @(posedge CLOCK);
        ex = (i == 0) ? |v : ((i == 1) ? &v : ^v);
        check("link", {31'h0, CTRL_OUT[0]}, {31'h0, ex});
      end
    end
    // third source left unselected drops out of the and
    set(8'h00, F_AND, 1'b0, 5'h01, 5'h02, 5'h00);
    for (int k = 0; k < 4; k++) begin
      v = 3'(k);
      drive({13'h0, v});
      repeat (3) @(posedge CLOCK);
      check("and_two", {31'h0, CTRL_OUT[0]}, {31'h0, &v[1:0]});
    end
  endtask

  task automatic t_pulse();
    int n;
    logic hi;
    drive(16'h0);
    wr(8'h08, 32'h2);
    wr(8'h0c, 32'h1);
    set(8'h00, F_PULSE, 1'b0, 5'h01, 5'h00, 5'h00);
    drive(16'h0001);
    wait_lvl(1'b1, 40, n);
    wait_lvl(1'b0, 40, n);
    wait_lvl(1'b1, 40, n);
    check("pulse_low", n, SEC);
    wait_lvl(1'b0, 40, n);
    check("pulse_high", n, 2 * SEC);
    drive(16'h0);
    // a phase change already under way still reaches the pin before the low input
    repeat (3) @(posedge CLOCK);
    hi = 1'b0;
    repeat (4 * SEC) begin
      @(posedge CLOCK);
      if (CTRL_OUT[0] !== 1'b0) hi = 1'b1;
    end
    check("pulse_idle", {31'h0, hi}, 32'h0);
  endtask

  task automatic t_delay();
    int n;
    set(8'h00, F_DELAY, 1'b0, 5'h01, 5'h00, 5'h00);
    drive(16'h0001);
    wait_lvl(1'b1, 40, n);
    check("delay_on", 32'(n >= SEC + 1 && n <= 2 * SEC + 4), 32'h1);
    drive(16'h0);
    wait_lvl(1'b0, 40, n);
    check("delay_off", 32'(n >= 2 && n <= SEC + 4), 32'h1);
  endtask

  task automatic t_single();
    int n;
    wr(8'h10, 32'h3);
    set(8'h00, F_SINGLE, 1'b0, 5'h01, 5'h00, 5'h00);
    drive(16'h0001);
    wait_lvl(1'b1, 10, n);
    wait_lvl(1'b0, 40, n);
    check("single_len", 32'(n >= 2 * SEC - 1 && n <= 3 * SEC + 2), 32'h1);
    drive(16'h0);
    drive(16'h0001);
    wait_lvl(1'b1, 10, n);
    // restart lands before the first pulse could end, so only a restart gives this length
    repeat (2) @(posedge CLOCK);
    drive(16'h0);
    drive(16'h0001);
    wait_lvl(1'b0, 40, n);
    check("single_restart", 32'(n >= 3 * SEC && n <= 4 * SEC), 32'h1);
  endtask

  task automatic t_edges();
    int n;
    set(8'h00, F_RISE, 1'b0, 5'h01, 5'h00, 5'h00);
    drive(16'h0);
    drive(16'h0001);
    wait_lvl(1'b1, 3 * TP, n);
    wait_lvl(1'b0, 3 * TP, n);
    check("rise_len", n, TP);
    set(8'h00, F_FALL, 1'b0, 5'h01, 5'h00, 5'h00);
    drive(16'h0);
    wait_lvl(1'b1, 3 * TP, n);
    wait_lvl(1'b0, 3 * TP, n);
    check("fall_len", n, TP);
  endtask

  initial begin
    CLOCK = 1'b0;
    RESET = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    want = 16'h0;
    err_total = 0;
    checks_done = 0;
    repeat (10) @(posedge CLOCK);
    RESET <= 1'b0;
    t_reset_regs();
    t_none_inv();
    t_links();
    t_pulse();
    t_delay();
    t_single();
    t_edges();
    finish_test();
  end
endmodule // tb
